//--- bench/sfc_frontend_assertions.sv
`timescale 1ns/1ps
module sfc_frontend_assertions (
   input wire        CLK,
   input wire        RST_N,
   input wire        SCLK,
   input wire        CS_N,
   input wire [3:0]  IO_OUT,
   input wire [3:0]  IO_OE,
   input wire        RD,
   input wire [31:0] RDATA,
   input wire        CMD_VALID,
   input wire        PD_VALID,
   input wire        PD_READY,
   input wire [7:0]  PD_DATA
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   sequence cs_idle;
      CS_N [*6];
   endsequence
   sequence pd_stall;
      PD_VALID && !PD_READY;
   endsequence
   idle_release_a: assert property (cs_idle |-> IO_OE == 4'h0)
      else $error("lanes driven while deselected");
   rdata_hold_a: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("read data outside its cycle");
   cmd_pulse_a: assert property (CMD_VALID |=> !CMD_VALID)
      else $error("command pulse too long");
   cmd_frame_a: assert property (CMD_VALID |-> CS_N && $past(CS_N, 3))
      else $error("command accepted inside a frame");
   lanes_legal_a: assert property (IO_OE inside {4'h0, 4'h2, 4'h3, 4'hf})
      else $error("illegal lane enable set");
   drive_in_frame_a: assert property ($rose(|IO_OE) |-> !CS_N && !$past(CS_N, 4))
      else $error("output started outside a frame");
   out_on_fall_a: assert property ($changed(IO_OUT) && |IO_OE |-> !$past(SCLK, 2))
      else $error("output changed away from a falling edge");
   pd_hold_a: assert property (pd_stall |=> PD_VALID && $stable(PD_DATA))
      else $error("program data lost during stall");
endmodule

//--- bench/sfc_host.sv
`timescale 1ns/1ps
module sfc_host (
   input  wire        clk,
   output logic       sclk,
   output logic       cs_n,
   output logic       mosi,
   input  wire  [3:0] pins
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // keeps every link edge off the rising edge of the system clock
   task automatic sel();
      @(negedge clk);
      #1;
      cs_n = 1'b0;
      #30;
   endtask
   // n bits msb first; device line sampled at each rise
   task automatic xfer(input int n, input logic [7:0] v, output logic [7:0] r);
      r = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         mosi = v[i];
         #24;
         sclk = 1'b1;
         r[i] = pins[1];
         #24;
         sclk = 1'b0;
      end
   endtask
   // released line shows the inverse of its last bit
   task automatic desel();
      #10;
      cs_n = 1'b1;
      mosi = ~mosi;
      #300;
   endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
`include "sfc_defs.vh"
module tb;
   logic        CLK = 1'b0;
   logic        RST_N = 1'b0;
   logic [7:0]  ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0;
   logic        WR = 1'b0;
   logic        RD = 1'b0;
   logic        PD_READY = 1'b0;
   wire         SCLK, CS_N, mosi, CMD_VALID, PD_VALID;
   wire  [3:0]  IO_IN, IO_OUT, IO_OE;
   wire  [31:0] RDATA;
   wire  [23:0] MEM_ADDR, CMD_ADDR;
   wire  [7:0]  MEM_RDATA, CMD_OP, PD_DATA;
   logic [31:0] err_count = 0, n_checks = 0, n_cmd = 0, c_op, c_ad, cyc = 0;
   logic        oe_any;
   always #2.5 CLK = ~CLK;
   assign MEM_RDATA = MEM_ADDR[7:0] ^ 8'h5a;
   assign IO_IN = {IO_OE[3] ? IO_OUT[3] : 1'b1, IO_OE[2] ? IO_OUT[2] : 1'b1,
                   IO_OE[1] ? IO_OUT[1] : CLK, IO_OE[0] ? IO_OUT[0] : mosi};
   sfc_host u_host (.clk(CLK), .sclk(SCLK), .cs_n(CS_N), .mosi(mosi), .pins(IO_IN));
   sfc_frontend u_dut (.CLK(CLK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N), .IO_IN(IO_IN),
      .IO_OUT(IO_OUT), .IO_OE(IO_OE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .MEM_ADDR(MEM_ADDR), .MEM_RDATA(MEM_RDATA), .CMD_VALID(CMD_VALID),
      .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .PD_VALID(PD_VALID), .PD_READY(PD_READY),
      .PD_DATA(PD_DATA));
   always @(posedge CLK) begin
      oe_any |= (IO_OE !== 4'h0);
      if (CMD_VALID === 1'b1) begin
         n_cmd++;
         c_op = {24'h0, CMD_OP};
         c_ad = {8'h0, CMD_ADDR};
      end
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      chk({24'h0, got}, {24'h0, exp});
   endtask
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      d = RDATA;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task automatic send(input logic [7:0] op, input int na, input logic [23:0] a);
      logic [7:0] r;
      u_host.sel();
      u_host.xfer(8, op, r);
      for (int i = 0; i < na; i++)
         u_host.xfer(8, a[23-8*i -: 8], r);
   endtask
   task automatic op1(input logic [7:0] op);
      send(op, 0, 24'h0);
      u_host.desel();
   endtask
   task automatic rdsr(input logic [7:0] op, input logic [7:0] e);
      logic [7:0] r;
      send(op, 0, 24'h0);
      repeat (2) begin
         u_host.xfer(8, 8'h00, r);
         chk8(r, e);
      end
      u_host.desel();
   endtask
   task automatic pull(input logic [7:0] e);
      int k;
      k = 0;
      while (PD_VALID !== 1'b1 && k < 100) begin
         @(posedge CLK);
         #1;
         k++;
      end
      chk8(PD_DATA, e);
      @(posedge CLK);
      PD_READY <= 1'b1;
      @(posedge CLK);
      PD_READY <= 1'b0;
      #1;
   endtask
   task automatic t_reset();
      logic [31:0] d;
      rreg(`SFC_REG_STATUS, d);
      chk(d, 32'h0);
      rreg(8'h20, d);
      chk(d, 32'h0);
   endtask
   task automatic t_latch();
      logic [7:0] r;
      op1(`SFC_OP_WREN);
      rdsr(`SFC_OP_RDSR0, 8'h02);
      send(`SFC_OP_WRDI, 0, 24'h0);
      u_host.xfer(1, 8'h00, r);
      u_host.desel();
      rdsr(`SFC_OP_RDSR0, 8'h02);
      op1(`SFC_OP_WRDI);
      rdsr(`SFC_OP_RDSR0, 8'h00);
   endtask
   task automatic t_erase();
      logic [7:0]  ops [5] = '{`SFC_OP_SE, `SFC_OP_BE32, `SFC_OP_BE64, `SFC_OP_CE1, `SFC_OP_CE2};
      logic [31:0] d, n;
      n = n_cmd;
      send(`SFC_OP_SE, 3, 24'h123456);
      u_host.desel();
      chk(n_cmd, n);
      foreach (ops[i]) begin
         op1(`SFC_OP_WREN);
         send(ops[i], (i < 3) ? 3 : 0, 24'h123456);
         u_host.desel();
         chk(n_cmd, n + i + 1);
         chk(c_op, {24'h0, ops[i]});
         if (i == 0)
            chk(c_ad, 32'h123456);
         rreg(`SFC_REG_STATUS, d);
         chk(d & 32'h1, 32'h1);
         wreg(`SFC_REG_CTRL, 32'h1);
         rreg(`SFC_REG_STATUS, d);
         chk(d & 32'h1, 32'h0);
      end
   endtask
   task automatic t_read();
      logic [7:0] r;
      send(`SFC_OP_READ, 3, 24'h000010);
      for (int i = 0; i < 2; i++) begin
         u_host.xfer(8, 8'h00, r);
         chk8(r, (8'h10 + i[7:0]) ^ 8'h5a);
      end
      u_host.xfer(3, 8'h00, r);
      u_host.desel();
      chk({28'h0, IO_OE}, 32'h0);
      send(`SFC_OP_FREAD, 3, 24'h000020);
      u_host.xfer(8, 8'h00, r);
      u_host.xfer(8, 8'h00, r);
      u_host.desel();
      chk8(r, 8'h7a);
   endtask
   task automatic t_prog();
      logic [7:0]  r;
      logic [31:0] n;
      n = n_cmd;
      op1(`SFC_OP_WREN);
      send(`SFC_OP_PP, 3, 24'h000100);
      u_host.xfer(8, 8'ha5, r);
      u_host.xfer(8, 8'h3c, r);
      u_host.xfer(4, 8'hf0, r);
      u_host.desel();
      chk(n_cmd, n);
      rdsr(`SFC_OP_RDSR0, 8'h02);
      pull(8'ha5);
      pull(8'h3c);
      send(`SFC_OP_PP, 3, 24'h000100);
      u_host.xfer(8, 8'h96, r);
      u_host.desel();
      chk(n_cmd, n + 1);
      pull(8'h96);
      wreg(`SFC_REG_CTRL, 32'h1);
   endtask
   task automatic t_quad();
      logic [7:0] r;
      oe_any = 1'b0;
      send(8'hff, 0, 24'h0);
      u_host.xfer(8, 8'h00, r);
      u_host.desel();
      send(`SFC_OP_QOFR, 3, 24'h0);
      u_host.xfer(8, 8'h00, r);
      u_host.xfer(8, 8'h00, r);
      u_host.desel();
      chk({31'h0, oe_any}, 32'h0);
      op1(`SFC_OP_VWREN);
      send(`SFC_OP_WRSR, 0, 24'h0);
      u_host.xfer(8, 8'h00, r);
      u_host.xfer(8, 8'h02, r);
      u_host.desel();
      rdsr(`SFC_OP_RDSR1, 8'h02);
      send(`SFC_OP_QOFR, 3, 24'h0);
      u_host.xfer(8, 8'h00, r);
      u_host.xfer(2, 8'h00, r);
      chk({28'h0, IO_OE}, 32'hf);
      u_host.desel();
   endtask
   task automatic t_misc();
      logic [7:0]  r;
      logic [31:0] d, n;
      send(`SFC_OP_WRAP, 0, 24'h0);
      u_host.xfer(8, 8'h50, r);
      u_host.desel();
      op1(`SFC_OP_QPI);
      rreg(`SFC_REG_MISC, d);
      chk(d & 32'hf, 32'hd);
      op1(`SFC_OP_WREN);
      op1(`SFC_OP_CE1);
      n = n_cmd;
      op1(`SFC_OP_SUSP);
      rdsr(`SFC_OP_RDSR1, 8'h82);
      op1(`SFC_OP_RESM);
      chk(n_cmd, n + 2);
      op1(`SFC_OP_RSTEN);
      op1(`SFC_OP_RST);
      rreg(`SFC_REG_MISC, d);
      chk(d & 32'hf, 32'h0);
      wreg(`SFC_REG_CTRL, 32'h1);
   endtask
   initial begin
      repeat (12) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (4) @(posedge CLK);
      t_reset();
      t_latch();
      t_erase();
      t_read();
      t_prog();
      t_quad();
      t_misc();
      summarize();
   end
endmodule
bind sfc_frontend sfc_frontend_assertions u_chk (.CLK(CLK), .RST_N(RST_N), .SCLK(SCLK),
   .CS_N(CS_N), .IO_OUT(IO_OUT), .IO_OE(IO_OE), .RD(RD), .RDATA(RDATA),
   .CMD_VALID(CMD_VALID), .PD_VALID(PD_VALID), .PD_READY(PD_READY), .PD_DATA(PD_DATA));

//--- rtl/sfc_buf2.v
`timescale 1ns/1ps
// two entries: output stage plus skid stage
module sfc_buf2 #(
   parameter W = 8
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   output wire         out_valid,
   input  wire         out_ready,
   output wire [W-1:0] out_data
);
   reg         ov_q;
   reg [W-1:0] od_q;
   reg         sv_q;
   reg [W-1:0] sd_q;
   always @(posedge clk) begin
      if (!rst_n) begin
         ov_q <= 1'b0;
         od_q <= {W{1'b0}};
         sv_q <= 1'b0;
         sd_q <= {W{1'b0}};
      end else if (out_ready || !ov_q) begin
         if (sv_q) begin
            ov_q <= 1'b1;
            od_q <= sd_q;
            sv_q <= 1'b0;
         end else begin
            ov_q <= in_valid;
            if (in_valid) od_q <= in_data;
         end
      end else if (in_valid && !sv_q) begin
         sv_q <= 1'b1;
         sd_q <= in_data;
      end
   end
   assign in_ready  = !sv_q;
   assign out_valid = ov_q;
   assign out_data  = od_q;
endmodule

//--- rtl/sfc_defs.vh
`ifndef SFC_DEFS_VH
`define SFC_DEFS_VH
// opcodes
`define SFC_OP_WREN   8'h06
`define SFC_OP_WRDI   8'h04
`define SFC_OP_VWREN  8'h50
`define SFC_OP_RDSR0  8'h05
`define SFC_OP_RDSR1  8'h35
`define SFC_OP_WRSR   8'h01
`define SFC_OP_READ   8'h03
`define SFC_OP_FREAD  8'h0b
`define SFC_OP_DOFR   8'h3b
`define SFC_OP_QOFR   8'h6b
`define SFC_OP_DIOFR  8'hbb
`define SFC_OP_QIOFR  8'heb
`define SFC_OP_QWFR   8'he7
`define SFC_OP_PP     8'h02
`define SFC_OP_QPP    8'h32
`define SFC_OP_SE     8'h20
`define SFC_OP_BE32   8'h52
`define SFC_OP_BE64   8'hd8
`define SFC_OP_CE1    8'hc7
`define SFC_OP_CE2    8'h60
`define SFC_OP_QPI    8'h38
`define SFC_OP_RSTEN  8'h66
`define SFC_OP_RST    8'h99
`define SFC_OP_WRAP   8'h77
`define SFC_OP_SUSP   8'h75
`define SFC_OP_RESM   8'h7a
`define SFC_OP_DPD    8'hb9
// frame states
`define SFC_ST_OP     3'h0
`define SFC_ST_ADDR   3'h1
`define SFC_ST_MODE   3'h2
`define SFC_ST_DUMMY  3'h3
`define SFC_ST_DOUT   3'h4
`define SFC_ST_DIN    3'h5
`define SFC_ST_IGN    3'h6
// status bits
`define SFC_S_BUSY    0
`define SFC_S_WLAT    1
`define SFC_S_QUAD    9
`define SFC_S_SUS2    10
`define SFC_S_SUS1    15
`define SFC_STAT_RST  16'h0000
`define SFC_STAT_WMSK 16'h7bfc
// lanes, byte and dummy clock counts
`define SFC_LN0       4'h0
`define SFC_LN1       4'h1
`define SFC_LN2       4'h2
`define SFC_LN4       4'h4
`define SFC_BYTE      4'h8
`define SFC_DCLK_NONE 4'h0
`define SFC_DCLK_FAST 4'h8
`define SFC_DCLK_QIO  4'h4
`define SFC_DCLK_QW   4'h2
`define SFC_ALAST     2'h2
// output byte sources
`define SFC_SRC_MEM   2'h0
`define SFC_SRC_SL    2'h1
`define SFC_SRC_SH    2'h2
// byte counts per frame, opcode included; least for WRSR and PP, exact for erase
`define SFC_NB_ONE    8'h01
`define SFC_NB_WRSR   8'h02
`define SFC_NB_WRSRH  8'h03
`define SFC_NB_ER     8'h04
`define SFC_NB_PP     8'h05
`define SFC_NB_MAX    8'hff
// register map
`define SFC_REG_STATUS 8'h00
`define SFC_REG_CTRL   8'h04
`define SFC_REG_LASTOP 8'h08
`define SFC_REG_ADDR   8'h0c
`define SFC_REG_MISC   8'h10
`define SFC_CTRL_DONE  0
`endif

//--- rtl/sfc_frontend.v
`timescale 1ns/1ps
`include "sfc_defs.vh"
module sfc_frontend (
   input  wire        CLK,
   input  wire        RST_N,
   input  wire        SCLK,
   input  wire        CS_N,
   input  wire [3:0]  IO_IN,
   output wire [3:0]  IO_OUT,
   output wire [3:0]  IO_OE,
   input  wire [7:0]  ADDR,
   input  wire [31:0] WDATA,
   input  wire        WR,
   input  wire        RD,
   output wire [31:0] RDATA,
   output wire [23:0] MEM_ADDR,
   input  wire [7:0]  MEM_RDATA,
   output wire        CMD_VALID,
   output wire [7:0]  CMD_OP,
   output wire [23:0] CMD_ADDR,
   output wire        PD_VALID,
   input  wire        PD_READY,
   output wire [7:0]  PD_DATA
);
   wire [5:0]  s;
   wire        sclk_s = s[5];
   wire        cs_s   = s[4];
   wire [3:0]  io_s   = s[3:0];
   reg         sclk_p_q;
   reg         cs_p_q;
   reg  [2:0]  st_q;
   reg  [7:0]  op_q;
   reg  [7:0]  sh_q;
   reg  [3:0]  nb_q;
   reg  [7:0]  bcnt_q;
   reg  [1:0]  ac_q;
   reg  [23:0] addr_q;
   reg  [7:0]  mode_q;
   reg  [3:0]  dcnt_q;
   reg  [3:0]  aln_q;
   reg         hasm_q;
   reg  [3:0]  dclk_q;
   reg  [3:0]  oln_q;
   reg  [1:0]  src_q;
   reg  [3:0]  dln_q;
   reg  [7:0]  osh_q;
   reg  [3:0]  oc_q;
   reg  [3:0]  io_out_q;
   reg  [3:0]  io_oe_q;
   reg  [23:0] mem_addr_q;
   reg  [15:0] stat_q;
   reg  [7:0]  wlo_q;
   reg  [7:0]  whi_q;
   reg         vwe_q;
   reg         rsten_q;
   reg         erase_q;
   reg  [2:0]  wrap_q;
   reg         qpi_q;
   reg         dpd_q;
   reg         ovr_q;
   reg         pend_q;
   reg  [7:0]  pend_d_q;
   reg         cmd_v_q;
   reg  [7:0]  cmd_op_q;
   reg  [23:0] cmd_a_q;
   reg  [31:0] rdata_q;
   wire        pd_in_rdy;
   wire        rise   = !cs_s && sclk_s && !sclk_p_q;
   wire        fall   = !cs_s && !sclk_s && sclk_p_q;
   wire        cs_end = cs_s && !cs_p_q;
   wire        quad_en = stat_q[`SFC_S_QUAD];
   wire        wr_lat  = stat_q[`SFC_S_WLAT];
   wire        busy    = stat_q[`SFC_S_BUSY];
   wire        algn   = (nb_q == `SFC_LN0);
   reg  [3:0]  in_ln;
   reg  [7:0]  ish;
   wire [3:0]  nb_n   = nb_q + in_ln;
   wire        bdone  = (nb_n == `SFC_BYTE);
   reg         dc_ok;
   reg         dc_a;
   reg         dc_m;
   reg  [3:0]  dc_aln;
   reg  [3:0]  dc_dclk;
   reg  [3:0]  dc_oln;
   reg  [1:0]  dc_src;
   reg  [3:0]  dc_dln;
   reg  [7:0]  src_b;
   reg  [7:0]  cur;
   reg  [2:0]  st_aa;
   wire [23:0] addr_n = {addr_q[15:0], ish};

   sfc_sync #(.W(6), .RST_V(6'h10)) u_sync (
      .clk   (CLK),
      .rst_n (RST_N),
      .d     ({SCLK, CS_N, IO_IN}),
      .q     (s)
   );

   sfc_buf2 #(.W(8)) u_buf (
      .clk       (CLK),
      .rst_n     (RST_N),
      .in_valid  (pend_q),
      .in_ready  (pd_in_rdy),
      .in_data   (pend_d_q),
      .out_valid (PD_VALID),
      .out_ready (PD_READY),
      .out_data  (PD_DATA)
   );

   // msb first shift, lanes per phase
   always @* begin
      case (st_q)
         `SFC_ST_ADDR, `SFC_ST_MODE: in_ln = aln_q;
         `SFC_ST_DIN:                in_ln = dln_q;
         default:                    in_ln = `SFC_LN1;
      endcase
      case (in_ln)
         `SFC_LN4: ish = {sh_q[3:0], io_s};
         `SFC_LN2: ish = {sh_q[5:0], io_s[1:0]};
         default:  ish = {sh_q[6:0], io_s[0]};
      endcase
   end

   // opcode decode
   always @* begin
      dc_ok   = 1'b1;
      dc_a    = 1'b0;
      dc_m    = 1'b0;
      dc_aln  = `SFC_LN1;
      dc_dclk = `SFC_DCLK_NONE;
      dc_oln  = `SFC_LN0;
      dc_src  = `SFC_SRC_MEM;
      dc_dln  = `SFC_LN1;
      case (ish)
         `SFC_OP_WREN, `SFC_OP_WRDI, `SFC_OP_VWREN: ;
         `SFC_OP_RDSR0: begin
            dc_oln = `SFC_LN1;
            dc_src = `SFC_SRC_SL;
         end
         `SFC_OP_RDSR1: begin
            dc_oln = `SFC_LN1;
            dc_src = `SFC_SRC_SH;
         end
         `SFC_OP_WRSR: ;
         `SFC_OP_READ: begin
            dc_a   = 1'b1;
            dc_oln = `SFC_LN1;
         end
         `SFC_OP_FREAD: begin
            dc_a    = 1'b1;
            dc_dclk = `SFC_DCLK_FAST;
            dc_oln  = `SFC_LN1;
         end
         `SFC_OP_DOFR: begin
            dc_a    = 1'b1;
            dc_dclk = `SFC_DCLK_FAST;
            dc_oln  = `SFC_LN2;
         end
         `SFC_OP_QOFR: begin
            dc_ok   = quad_en;
            dc_a    = 1'b1;
            dc_dclk = `SFC_DCLK_FAST;
            dc_oln  = `SFC_LN4;
         end
         `SFC_OP_DIOFR: begin
            dc_a   = 1'b1;
            dc_m   = 1'b1;
            dc_aln = `SFC_LN2;
            dc_oln = `SFC_LN2;
         end
         `SFC_OP_QIOFR, `SFC_OP_QWFR: begin
            dc_ok   = quad_en;
            dc_a    = 1'b1;
            dc_m    = 1'b1;
            dc_aln  = `SFC_LN4;
            dc_oln  = `SFC_LN4;
            dc_dclk = (ish == `SFC_OP_QWFR) ? `SFC_DCLK_QW : `SFC_DCLK_QIO;
         end
         `SFC_OP_PP: dc_a = 1'b1;
         `SFC_OP_QPP: begin
            dc_ok  = quad_en;
            dc_a   = 1'b1;
            dc_dln = `SFC_LN4;
         end
         `SFC_OP_SE, `SFC_OP_BE32, `SFC_OP_BE64: dc_a = 1'b1;
         `SFC_OP_CE1, `SFC_OP_CE2, `SFC_OP_DPD: ;
         `SFC_OP_QPI, `SFC_OP_RSTEN, `SFC_OP_RST, `SFC_OP_WRAP,
         `SFC_OP_SUSP, `SFC_OP_RESM: ;
         default: dc_ok = 1'b0;
      endcase
   end

   // byte to send, phase after address
   always @* begin
      case (src_q)
         `SFC_SRC_SL: src_b = stat_q[7:0];
         `SFC_SRC_SH: src_b = stat_q[15:8];
         default:     src_b = MEM_RDATA;
      endcase
      cur = (oc_q == `SFC_LN0) ? src_b : osh_q;
      if (hasm_q)
         st_aa = `SFC_ST_MODE;
      else if (dclk_q != `SFC_DCLK_NONE)
         st_aa = `SFC_ST_DUMMY;
      else if (oln_q != `SFC_LN0)
         st_aa = `SFC_ST_DOUT;
      else
         st_aa = `SFC_ST_DIN;
   end

   always @(posedge CLK) begin
      if (!RST_N) begin
         sclk_p_q <= 1'b0;
         cs_p_q <= 1'b1;
         st_q <= `SFC_ST_OP;
         op_q <= 8'h00;
         sh_q <= 8'h00;
         nb_q <= `SFC_LN0;
         bcnt_q <= 8'h00;
         ac_q <= 2'h0;
         addr_q <= 24'h000000;
         mode_q <= 8'h00;
         dcnt_q <= 4'h0;
         aln_q <= `SFC_LN1;
         hasm_q <= 1'b0;
         dclk_q <= `SFC_DCLK_NONE;
         oln_q <= `SFC_LN0;
         src_q <= `SFC_SRC_MEM;
         dln_q <= `SFC_LN1;
         osh_q <= 8'h00;
         oc_q <= `SFC_LN0;
         io_out_q <= 4'h0;
         io_oe_q <= 4'h0;
         mem_addr_q <= 24'h000000;
         stat_q <= `SFC_STAT_RST;
         wlo_q <= 8'h00;
         whi_q <= 8'h00;
         vwe_q <= 1'b0;
         rsten_q <= 1'b0;
         erase_q <= 1'b0;
         wrap_q <= 3'h0;
         qpi_q <= 1'b0;
         dpd_q <= 1'b0;
         ovr_q <= 1'b0;
         pend_q <= 1'b0;
         pend_d_q <= 8'h00;
         cmd_v_q <= 1'b0;
         cmd_op_q <= 8'h00;
         cmd_a_q <= 24'h000000;
         rdata_q <= 32'h00000000;
      end else begin
         sclk_p_q <= sclk_s;
         cs_p_q <= cs_s;
         cmd_v_q <= 1'b0;
         if (pend_q && pd_in_rdy) pend_q <= 1'b0;
         rdata_q <= 32'h00000000;
         if (RD) begin
            case (ADDR)
               `SFC_REG_STATUS: rdata_q <= {16'h0000, stat_q};
               `SFC_REG_LASTOP: rdata_q <= {24'h000000, op_q};
               `SFC_REG_ADDR:   rdata_q <= {8'h00, addr_q};
               `SFC_REG_MISC:   rdata_q <= {24'h000000, mode_q[1:0], ovr_q, dpd_q,
                                            qpi_q, wrap_q};
               default:         rdata_q <= 32'h00000000;
            endcase
         end
         // software reports operation finished
         if (WR && ADDR == `SFC_REG_CTRL && WDATA[`SFC_CTRL_DONE])
            stat_q[`SFC_S_BUSY] <= 1'b0;
         if (cs_s) begin
            st_q <= `SFC_ST_OP;
            nb_q <= `SFC_LN0;
            bcnt_q <= 8'h00;
            oc_q <= `SFC_LN0;
            io_oe_q <= 4'h0;
            io_out_q <= 4'h0;
         end
         if (cs_end) begin
            if (op_q != `SFC_OP_RSTEN) rsten_q <= 1'b0;
            case (op_q)
               `SFC_OP_WREN: if (algn) stat_q[`SFC_S_WLAT] <= 1'b1;
               `SFC_OP_WRDI: if (algn) stat_q[`SFC_S_WLAT] <= 1'b0;
               `SFC_OP_VWREN: if (algn) vwe_q <= 1'b1;
               `SFC_OP_WRSR:
                  if (algn && bcnt_q >= `SFC_NB_WRSR && (wr_lat || vwe_q) && !busy) begin
                     stat_q <= (stat_q & ~`SFC_STAT_WMSK) | (`SFC_STAT_WMSK &
                               {(bcnt_q >= `SFC_NB_WRSRH) ? whi_q : stat_q[15:8], wlo_q});
                     if (!vwe_q) begin
                        stat_q[`SFC_S_BUSY] <= 1'b1;
                        cmd_v_q <= 1'b1;
                     end
                     vwe_q <= 1'b0;
                  end
               `SFC_OP_PP, `SFC_OP_QPP:
                  if (algn && bcnt_q >= `SFC_NB_PP && wr_lat && !busy) begin
                     stat_q[`SFC_S_BUSY] <= 1'b1;
                     stat_q[`SFC_S_WLAT] <= 1'b0;
                     cmd_v_q <= 1'b1;
                     erase_q <= 1'b0;
                  end
               `SFC_OP_SE, `SFC_OP_BE32, `SFC_OP_BE64, `SFC_OP_CE1, `SFC_OP_CE2:
                  if (algn && wr_lat && !busy && bcnt_q == ((op_q == `SFC_OP_CE1 ||
                      op_q == `SFC_OP_CE2) ? `SFC_NB_ONE : `SFC_NB_ER)) begin
                     stat_q[`SFC_S_BUSY] <= 1'b1;
                     stat_q[`SFC_S_WLAT] <= 1'b0;
                     cmd_v_q <= 1'b1;
                     erase_q <= 1'b1;
                  end
               `SFC_OP_DPD:
                  if (algn) begin
                     dpd_q <= 1'b1;
                     cmd_v_q <= 1'b1;
                  end
               `SFC_OP_QPI: qpi_q <= 1'b1;
               `SFC_OP_RSTEN: rsten_q <= 1'b1;
               `SFC_OP_RST:
                  if (rsten_q) begin
                     stat_q[`SFC_S_WLAT] <= 1'b0;
                     stat_q[`SFC_S_SUS1] <= 1'b0;
                     stat_q[`SFC_S_SUS2] <= 1'b0;
                     vwe_q <= 1'b0;
                     wrap_q <= 3'h0;
                     qpi_q <= 1'b0;
                     dpd_q <= 1'b0;
                  end
               `SFC_OP_SUSP:
                  if (busy) begin
                     stat_q[`SFC_S_BUSY] <= 1'b0;
                     stat_q[`SFC_S_SUS1] <= erase_q;
                     stat_q[`SFC_S_SUS2] <= !erase_q;
                     cmd_v_q <= 1'b1;
                  end
               `SFC_OP_RESM:
                  if (stat_q[`SFC_S_SUS1] || stat_q[`SFC_S_SUS2]) begin
                     stat_q[`SFC_S_BUSY] <= 1'b1;
                     stat_q[`SFC_S_SUS1] <= 1'b0;
                     stat_q[`SFC_S_SUS2] <= 1'b0;
                     cmd_v_q <= 1'b1;
                  end
               default: ;
            endcase
            cmd_op_q <= op_q;
            cmd_a_q <= addr_q;
         end else if (rise) begin
            if (st_q == `SFC_ST_OP || st_q == `SFC_ST_ADDR ||
                st_q == `SFC_ST_MODE || st_q == `SFC_ST_DIN) begin
               sh_q <= ish;
               nb_q <= bdone ? `SFC_LN0 : nb_n;
               if (bdone && bcnt_q != `SFC_NB_MAX) bcnt_q <= bcnt_q + 8'h01;
            end
            case (st_q)
               `SFC_ST_OP: if (bdone) begin
                  op_q <= ish;
                  ac_q <= 2'h0;
                  dcnt_q <= 4'h0;
                  aln_q <= dc_aln;
                  hasm_q <= dc_m;
                  dclk_q <= dc_dclk;
                  oln_q <= dc_oln;
                  src_q <= dc_src;
                  dln_q <= dc_dln;
                  if (!dc_ok) st_q <= `SFC_ST_IGN;
                  else if (dc_a) st_q <= `SFC_ST_ADDR;
                  else if (dc_oln != `SFC_LN0) st_q <= `SFC_ST_DOUT;
                  else st_q <= `SFC_ST_DIN;
               end
               `SFC_ST_ADDR: if (bdone) begin
                  addr_q <= addr_n;
                  ac_q <= ac_q + 2'h1;
                  if (ac_q == `SFC_ALAST) begin
                     mem_addr_q <= addr_n;
                     st_q <= st_aa;
                  end
               end
               `SFC_ST_MODE: if (bdone) begin
                  mode_q <= ish;
                  st_q <= (dclk_q != `SFC_DCLK_NONE) ? `SFC_ST_DUMMY : `SFC_ST_DOUT;
               end
               `SFC_ST_DUMMY: begin
                  dcnt_q <= dcnt_q + 4'h1;
                  if (dcnt_q == dclk_q - `SFC_LN1) st_q <= `SFC_ST_DOUT;
               end
               `SFC_ST_DIN: if (bdone) begin
                  if (op_q == `SFC_OP_PP || op_q == `SFC_OP_QPP) begin
                     if (pend_q && !pd_in_rdy) ovr_q <= 1'b1;
                     pend_q <= 1'b1;
                     pend_d_q <= ish;
                  end
                  if (op_q == `SFC_OP_WRSR && bcnt_q == `SFC_NB_ONE) wlo_q <= ish;
                  if (op_q == `SFC_OP_WRSR && bcnt_q == `SFC_NB_WRSR) whi_q <= ish;
                  if (op_q == `SFC_OP_WRAP && bcnt_q == `SFC_NB_ONE)
                     wrap_q <= ish[6:4];
               end
               default: ;
            endcase
         end else if (fall && st_q == `SFC_ST_DOUT) begin
            case (oln_q)
               `SFC_LN4: begin
                  io_out_q <= cur[7:4];
                  io_oe_q <= 4'hf;
               end
               `SFC_LN2: begin
                  io_out_q <= {2'b00, cur[7:6]};
                  io_oe_q <= 4'h3;
               end
               default: begin
                  io_out_q <= {2'b00, cur[7], 1'b0};
                  io_oe_q <= 4'h2;
               end
            endcase
            osh_q <= cur << oln_q;
            oc_q <= (oc_q + oln_q == `SFC_BYTE) ? `SFC_LN0 : oc_q + oln_q;
            if (oc_q == `SFC_LN0 && src_q == `SFC_SRC_MEM)
               mem_addr_q <= mem_addr_q + 24'h000001;
         end
      end
   end

   assign IO_OUT    = io_out_q;
   assign IO_OE     = io_oe_q;
   assign RDATA     = rdata_q;
   assign MEM_ADDR  = mem_addr_q;
   assign CMD_VALID = cmd_v_q;
   assign CMD_OP    = cmd_op_q;
   assign CMD_ADDR  = cmd_a_q;
endmodule

//--- rtl/sfc_sync.v
`timescale 1ns/1ps
module sfc_sync #(
   parameter       W     = 1,
   parameter [W-1:0] RST_V = {W{1'b0}}
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] m_q;
   reg [W-1:0] s_q;
   always @(posedge clk) begin
      if (!rst_n) begin
         m_q <= RST_V;
         s_q <= RST_V;
      end else begin
         m_q <= d;
         s_q <= m_q;
      end
   end
   assign q = s_q;
endmodule
